// file: psc_pkg.sv
// Shared types and constants for the strap mode configuration block
package psc_pkg;

  // Clock rates
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned AN_CLK_HZ = 25_000_000;

  // Strap sampling timing, in clock cycles; SAMPLE_PERIODS counts 25 MHz strap clock periods
  localparam logic [5:0] SETTLE_CYCLES = 6'h04;
  localparam int unsigned SAMPLE_PERIODS = 16;
  localparam int unsigned SAMPLE_CYCLES_INT =
    (SAMPLE_PERIODS * CLK_HZ + AN_CLK_HZ - 1) / AN_CLK_HZ;
  localparam logic [5:0] SAMPLE_CYCLES = SAMPLE_CYCLES_INT[5:0];
  localparam logic [3:0] MIN_TOGGLES = 4'h4;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CFG = 6'h17;
  localparam logic [5:0] IDX_LBR = 6'h18;
  localparam logic [5:0] IDX_TST = 6'h1b;
  localparam logic [5:0] IDX_STRAP = 6'h1d;

  // Field positions
  localparam int unsigned CFG_REPEATER_BIT = 12;
  localparam int unsigned LBR_BP_ALIGN_BIT = 12;
  localparam int unsigned LBR_BP_SCR_BIT = 13;
  localparam int unsigned LBR_BP_CODE_BIT = 14;
  localparam int unsigned TST_SERIAL_BIT = 9;

  // Values after reset
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] LBR_RST = 16'h0000;
  localparam logic [15:0] TST_RST = 16'h0000;

  // Advertised ability bits: {100 FD, 100 HD, 10 FD, 10 HD}
  localparam logic [3:0] ADV_10_BOTH = 4'h3;
  localparam logic [3:0] ADV_100_BOTH = 4'hc;
  localparam logic [3:0] ADV_ALL_FD = 4'ha;
  localparam logic [3:0] ADV_ALL_HD = 4'h5;
  localparam logic [3:0] ADV_ALL = 4'hf;

  typedef enum logic [1:0] {
    PSC_LVL_0, PSC_LVL_1, PSC_LVL_M, PSC_LVL_C
  } psc_level_t;

  typedef enum logic [1:0] {
    PSC_PH_SETTLE, PSC_PH_SAMPLE, PSC_PH_RUN
  } psc_phase_t;

  typedef struct packed {
    logic first;
    logic first_open;
    logic second;
    logic second_open;
    logic repeater;
    logic serial;
    logic bp_align;
    logic bp_code;
    logic bp_scr;
  } psc_strap_t;

  typedef struct packed {
    logic en;
    logic er_d4;
    logic [3:0] data;
  } psc_tx_t;

endpackage

// file: psc_strap_config.sv
// Strap capture, mode registers and mode application for a 10/100 PHY
// What this block does
// - Read second autoneg strap as 0, 1, open or clock; sample at reset
// - First strap low, second clocked: advertise 10BASE-T half and full
// - Repeater strap high selects repeater mode, low selects node mode
// - Repeater or full-duplex node: carrier sense from receive only
// - Half-duplex node: carrier sense from receive or transmit
// - Carrier integrity monitor off in node mode, on in repeater mode
// - Repeater strap captured into configuration bit 12 at reset
// - Configuration register lives at management address 17h
// - Serial strap high: 10 Mb/s data on bit 0 of each MII bus
// - Serial strap ignored while running at 100 Mb/s
// - Serial strap low: data exchanged as four-bit nibbles
// - Serial strap captured into bit 9 of register 1Bh at reset
// - Alignment bypass: 100 Mb/s data skips all coding; status void
// - Alignment bypass: fifth transmit bit always active
// - Alignment bypass strap captured into bit 12 of register 18h
// - Block code bypass: skip 4B/5B coding, status stays valid
// - Block code bypass: fifth transmit bit gated by transmit enable
// - Block code bypass strap captured into bit 14 of register 18h
// - Scrambler bypass: skip scrambler and descrambler, status valid
// - Scrambler bypass strap captured into bit 13 of register 18h
`timescale 1ns/100ps
module psc_strap_config (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Strap pins
  input wire psc_pkg::psc_strap_t strap_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Link status from the datapath
  input wire logic speed100_i,
  input wire logic full_duplex_i,
  input wire logic rx_active_i,
  input wire logic tx_active_i,
  // MII transmit from MAC, receive nibble from decoder
  input wire psc_pkg::psc_tx_t mii_tx_i,
  input wire logic [3:0] rx_data_i,
  // Mode outputs
  output logic crs_o,
  output logic cim_enable_o,
  output logic serial_mode_o,
  output logic bp_align_o,
  output logic bp_code_o,
  output logic bp_scr_o,
  output logic [3:0] an_adv_o,
  output logic ready_o,
  // Datapath outputs
  output psc_pkg::psc_tx_t tx_o,
  output logic [3:0] rxd_o
);

  typedef struct packed {
    psc_pkg::psc_phase_t phase;
    logic ready;
    psc_pkg::psc_strap_t sync1;
    psc_pkg::psc_strap_t sync2;
    psc_pkg::psc_strap_t sync3;
    psc_pkg::psc_strap_t stable;
    logic [5:0] cnt;
    logic [3:0] toggles;
    logic [3:0] toggles_first;
    psc_pkg::psc_level_t lvl_first;
    psc_pkg::psc_level_t lvl_second;
    logic [3:0] adv;
    logic [15:0] cfg;
    logic [15:0] lbr;
    logic [15:0] tst;
    logic ack;
    logic [31:0] rdata;
    logic crs;
    logic carrier_integrity_monitor;
    logic serial;
    logic bp_align;
    logic bp_code;
    logic bp_scr;
    psc_pkg::psc_tx_t tx;
    logic [3:0] rxd;
  } psc_state_t;

  psc_state_t s;
  psc_state_t next_s;

  // Four-level decode; a toggling pin wins over open and tied levels
  function automatic psc_pkg::psc_level_t psc_level(
    input logic lvl, input logic open, input logic [3:0] tog);
    psc_pkg::psc_level_t r;
    if (tog >= psc_pkg::MIN_TOGGLES) begin
      r = psc_pkg::PSC_LVL_C;
    end else if (open) begin
      r = psc_pkg::PSC_LVL_M;
    end else if (lvl) begin
      r = psc_pkg::PSC_LVL_1;
    end else begin
      r = psc_pkg::PSC_LVL_0;
    end
    return r;
  endfunction

  // Advertisement for the clock-level rows; other codes advertise all
  function automatic logic [3:0] psc_adv(
    input psc_pkg::psc_level_t a0, input psc_pkg::psc_level_t a1);
    logic [3:0] r;
    r = psc_pkg::ADV_ALL;
    if (a0 == psc_pkg::PSC_LVL_0 && a1 == psc_pkg::PSC_LVL_C) begin
      r = psc_pkg::ADV_10_BOTH;
    end else if (a0 == psc_pkg::PSC_LVL_C && a1 == psc_pkg::PSC_LVL_1) begin
      r = psc_pkg::ADV_ALL_FD;
    end else if (a0 == psc_pkg::PSC_LVL_C && a1 == psc_pkg::PSC_LVL_0) begin
      r = psc_pkg::ADV_ALL_HD;
    end else if (a0 == psc_pkg::PSC_LVL_1 && a1 == psc_pkg::PSC_LVL_C) begin
      r = psc_pkg::ADV_100_BOTH;
    end
    return r;
  endfunction

  // Byte-lane write of a 16-bit register held in the low lanes
  function automatic logic [15:0] psc_wr16(
    input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  logic wb_req;
  logic [5:0] wb_idx;
  assign wb_req = wb_cyc_i & wb_stb_i & ~s.ack;
  assign wb_idx = wb_adr_i[7:2];

  always_comb begin
    logic rep;
    logic align;
    logic code;
    logic ser;
    rep = 1'b0;
    align = 1'b0;
    code = 1'b0;
    ser = 1'b0;
    next_s = s;
    if (ce_i) begin
      // Pin synchroniser; a change counts once stages two and three agree
      next_s.sync1 = strap_i;
      next_s.sync2 = s.sync1;
      next_s.sync3 = s.sync2;
      next_s.stable = psc_pkg::psc_strap_t'((s.sync2 & s.sync3) |
        (s.stable & (s.sync2 ^ s.sync3)));

      // Clock level shows up as toggles during the sample window
      if (s.phase == psc_pkg::PSC_PH_SAMPLE &&
          next_s.stable.second != s.stable.second &&
          s.toggles != 4'hf) begin
        next_s.toggles = s.toggles + 4'h1;
      end
      if (s.phase == psc_pkg::PSC_PH_SAMPLE &&
          next_s.stable.first != s.stable.first &&
          s.toggles_first != 4'hf) begin
        next_s.toggles_first = s.toggles_first + 4'h1;
      end

      unique case (s.phase)
        psc_pkg::PSC_PH_SETTLE: begin
          next_s.cnt = s.cnt + 6'h01;
          if (s.cnt == psc_pkg::SETTLE_CYCLES - 6'h01) begin
            next_s.phase = psc_pkg::PSC_PH_SAMPLE;
            next_s.cnt = 6'h00;
            next_s.toggles = 4'h0;
            next_s.toggles_first = 4'h0;
          end
        end
        psc_pkg::PSC_PH_SAMPLE: begin
          next_s.cnt = s.cnt + 6'h01;
          if (s.cnt == psc_pkg::SAMPLE_CYCLES - 6'h01) begin
            // One-time capture; afterwards only software changes these
            next_s.phase = psc_pkg::PSC_PH_RUN;
            next_s.lvl_first = psc_level(s.stable.first,
              s.stable.first_open, next_s.toggles_first);
            next_s.lvl_second = psc_level(s.stable.second,
              s.stable.second_open, next_s.toggles);
            next_s.adv = psc_adv(next_s.lvl_first,
              next_s.lvl_second);
            next_s.cfg[psc_pkg::CFG_REPEATER_BIT] =
              s.stable.repeater;
            next_s.tst[psc_pkg::TST_SERIAL_BIT] = s.stable.serial;
            next_s.lbr[psc_pkg::LBR_BP_ALIGN_BIT] =
              s.stable.bp_align;
            next_s.lbr[psc_pkg::LBR_BP_CODE_BIT] =
              s.stable.bp_code;
            next_s.lbr[psc_pkg::LBR_BP_SCR_BIT] = s.stable.bp_scr;
          end
        end
        psc_pkg::PSC_PH_RUN: begin
          next_s.cnt = s.cnt;
        end
        default: begin
          next_s.phase = psc_pkg::PSC_PH_SETTLE;
        end
      endcase
      next_s.ready = next_s.phase == psc_pkg::PSC_PH_RUN;

      // Register access: one wait state; writes land with ack
      next_s.ack = wb_req;
      if (wb_req) begin
        next_s.rdata = 32'h0000_0000;
        unique case (wb_idx)
          psc_pkg::IDX_CFG: next_s.rdata[15:0] = s.cfg;
          psc_pkg::IDX_LBR: next_s.rdata[15:0] = s.lbr;
          psc_pkg::IDX_TST: next_s.rdata[15:0] = s.tst;
          psc_pkg::IDX_STRAP: next_s.rdata[8:0] =
            {s.phase == psc_pkg::PSC_PH_RUN, s.adv,
             s.lvl_second, s.lvl_first};
          default: next_s.rdata = 32'h0000_0000;
        endcase
      end
      if (wb_cyc_i && wb_stb_i && wb_we_i && s.ack &&
          s.phase == psc_pkg::PSC_PH_RUN) begin
        unique case (wb_idx)
          psc_pkg::IDX_CFG: next_s.cfg = psc_wr16(s.cfg, wb_dat_i,
            wb_sel_i);
          psc_pkg::IDX_LBR: next_s.lbr = psc_wr16(s.lbr, wb_dat_i,
            wb_sel_i);
          psc_pkg::IDX_TST: next_s.tst = psc_wr16(s.tst, wb_dat_i,
            wb_sel_i);
          default: next_s.rdata = next_s.rdata;
        endcase
      end

      // Modes follow the register bits, never the live pins
      if (s.phase == psc_pkg::PSC_PH_RUN) begin
        rep = s.cfg[psc_pkg::CFG_REPEATER_BIT];
        align = s.lbr[psc_pkg::LBR_BP_ALIGN_BIT] & speed100_i;
        code = s.lbr[psc_pkg::LBR_BP_CODE_BIT] & speed100_i;
        ser = s.tst[psc_pkg::TST_SERIAL_BIT] & ~speed100_i;
      end
      next_s.carrier_integrity_monitor = rep;
      next_s.serial = ser;
      next_s.bp_align = align;
      next_s.bp_code = code;
      next_s.bp_scr = s.phase == psc_pkg::PSC_PH_RUN &&
        s.lbr[psc_pkg::LBR_BP_SCR_BIT] && speed100_i;

      // Carrier sense held low while it carries no meaning
      if (s.phase != psc_pkg::PSC_PH_RUN || align) begin
        next_s.crs = 1'b0;
      end else if (rep || full_duplex_i) begin
        next_s.crs = rx_active_i;
      end else begin
        next_s.crs = rx_active_i | tx_active_i;
      end

      // Serial uses bit 0 only; nibble mode passes all four
      next_s.tx.en = mii_tx_i.en;
      next_s.tx.data = ser ? {3'h0, mii_tx_i.data[0]} :
        mii_tx_i.data;
      next_s.rxd = ser ? {3'h0, rx_data_i[0]} : rx_data_i;
      if (align) begin
        next_s.tx.er_d4 = mii_tx_i.er_d4;
      end else begin
        next_s.tx.er_d4 = mii_tx_i.er_d4 & mii_tx_i.en;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.phase <= psc_pkg::PSC_PH_SETTLE;
      s.cfg <= psc_pkg::CFG_RST;
      s.lbr <= psc_pkg::LBR_RST;
      s.tst <= psc_pkg::TST_RST;
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;
  assign crs_o = s.crs;
  assign cim_enable_o = s.carrier_integrity_monitor;
  assign serial_mode_o = s.serial;
  assign bp_align_o = s.bp_align;
  assign bp_code_o = s.bp_code;
  assign bp_scr_o = s.bp_scr;
  assign an_adv_o = s.adv;
  assign ready_o = s.ready;
  assign tx_o = s.tx;
  assign rxd_o = s.rxd;

  // Checks
  logic run;
  logic cap;
  assign run = s.phase == psc_pkg::PSC_PH_RUN;
  assign cap = s.phase == psc_pkg::PSC_PH_SAMPLE && ce_i &&
    s.cnt == psc_pkg::SAMPLE_CYCLES - 6'h01;

  property p_crs_half;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && run && !s.cfg[psc_pkg::CFG_REPEATER_BIT] &&
       !full_duplex_i && tx_active_i &&
       !(s.lbr[psc_pkg::LBR_BP_ALIGN_BIT] && speed100_i)) |=> crs_o;
  endproperty
  a_crs_half: assert property (p_crs_half)
    else $error("carrier sense missed transmit activity");

  property p_crs_rx_only;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && run && !rx_active_i &&
       (s.cfg[psc_pkg::CFG_REPEATER_BIT] || full_duplex_i)) |=> !crs_o;
  endproperty
  a_crs_rx_only: assert property (p_crs_rx_only)
    else $error("carrier sense asserted without receive");

  property p_cim;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && run) |=> cim_enable_o ==
        $past(s.cfg[psc_pkg::CFG_REPEATER_BIT]);
  endproperty
  a_cim: assert property (p_cim)
    else $error("integrity monitor does not follow mode");

  property p_cap_rep;
    @(posedge clk_i) disable iff (rst_i)
      cap |=> s.cfg[psc_pkg::CFG_REPEATER_BIT] ==
        $past(s.stable.repeater) ##1 !ce_i || run;
  endproperty
  a_cap_rep: assert property (p_cap_rep)
    else $error("repeater strap not captured");

  property p_cap_ser;
    @(posedge clk_i) disable iff (rst_i)
      cap |=> s.tst[psc_pkg::TST_SERIAL_BIT] == $past(s.stable.serial);
  endproperty
  a_cap_ser: assert property (p_cap_ser)
    else $error("serial strap not captured");

  property p_cap_bp;
    @(posedge clk_i) disable iff (rst_i)
      cap |=> s.lbr[14:12] == $past({s.stable.bp_code,
        s.stable.bp_scr, s.stable.bp_align});
  endproperty
  a_cap_bp: assert property (p_cap_bp)
    else $error("bypass straps not captured");

  property p_ser_100;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && speed100_i) |=> !serial_mode_o;
  endproperty
  a_ser_100: assert property (p_ser_100)
    else $error("serial mode active at 100 Mb/s");

  property p_ser_data;
    @(posedge clk_i) disable iff (rst_i)
      serial_mode_o |-> tx_o.data[3:1] == 3'h0 && rxd_o[3:1] == 3'h0;
  endproperty
  a_ser_data: assert property (p_ser_data)
    else $error("serial mode drives upper data bits");

  property p_d4_align;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && run && speed100_i && s.lbr[psc_pkg::LBR_BP_ALIGN_BIT])
        |=> tx_o.er_d4 == $past(mii_tx_i.er_d4);
  endproperty
  a_d4_align: assert property (p_d4_align)
    else $error("fifth transmit bit not always active");

  property p_d4_code;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && !mii_tx_i.en && !(run && speed100_i &&
       s.lbr[psc_pkg::LBR_BP_ALIGN_BIT])) |=> !tx_o.er_d4;
  endproperty
  a_d4_code: assert property (p_d4_code)
    else $error("fifth transmit bit not gated by enable");

  property p_adv_10;
    @(posedge clk_i) disable iff (rst_i)
      (run && s.lvl_first == psc_pkg::PSC_LVL_0 &&
       s.lvl_second == psc_pkg::PSC_LVL_C) |-> an_adv_o == 4'h3;
  endproperty
  a_adv_10: assert property (p_adv_10)
    else $error("wrong advertisement for clocked strap");

endmodule

// file: psc_strap_model.sv
// Strap resistor model: four-level autoneg pads and plain mode straps
`timescale 1ns/100ps
module psc_strap_model (
  // Requested pad settings
  input wire psc_pkg::psc_level_t first_lvl_i,
  input wire psc_pkg::psc_level_t second_lvl_i,
  input wire logic [4:0] mode_i,
  // Pad levels seen by the block
  output psc_pkg::psc_strap_t strap_o
);
  logic osc;

  // Free running 25 MHz source, unrelated to the block clock
  initial begin
    osc = 1'b0;
    forever #20 osc = ~osc;
  end

  // Open pads read low; the block must use the open flag
  always_comb begin
    strap_o.first = (first_lvl_i == psc_pkg::PSC_LVL_1) |
      ((first_lvl_i == psc_pkg::PSC_LVL_C) & osc);
    strap_o.first_open = first_lvl_i == psc_pkg::PSC_LVL_M;
    strap_o.second = (second_lvl_i == psc_pkg::PSC_LVL_1) |
      ((second_lvl_i == psc_pkg::PSC_LVL_C) & osc);
    strap_o.second_open = second_lvl_i == psc_pkg::PSC_LVL_M;
    {strap_o.repeater, strap_o.serial, strap_o.bp_align, strap_o.bp_code,
      strap_o.bp_scr} = mode_i;
  end
endmodule

// file: tb_psc_strap_config.sv
// Self-checking testbench for the strap mode configuration block
`timescale 1ns/100ps
module tb_psc_strap_config;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic [3:0] wb_sel, an_adv, rxd, rx_data;
  logic speed100, full_dup, rx_act, tx_act, crs, carrier_integrity_monitor, serial;
  logic bpa, bpc, bps, ready, ce;
  psc_pkg::psc_level_t lvl_a, lvl_b;
  logic [4:0] mode;
  psc_pkg::psc_strap_t strap;
  psc_pkg::psc_tx_t mii_tx, tx;
  int mismatches, samples_checked;

  psc_strap_model i_straps (.first_lvl_i(lvl_a), .second_lvl_i(lvl_b),
    .mode_i(mode), .strap_o(strap));

  psc_strap_config i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .strap_i(strap), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat_w), .wb_sel_i(wb_sel),
    .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .speed100_i(speed100),
    .full_duplex_i(full_dup), .rx_active_i(rx_act), .tx_active_i(tx_act),
    .mii_tx_i(mii_tx), .rx_data_i(rx_data), .crs_o(crs),
    .cim_enable_o(carrier_integrity_monitor), .serial_mode_o(serial), .bp_align_o(bpa),
    .bp_code_o(bpc), .bp_scr_o(bps), .an_adv_o(an_adv), .ready_o(ready),
    .tx_o(tx), .rxd_o(rxd));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Inputs land at one edge; registered outputs are read just after it
  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask

  // Straps stay steady through reset and the whole sampling window
  task automatic boot(input psc_pkg::psc_level_t a, b, input logic [4:0] m);
    int n;
    @(posedge clk_i);
    rst_i <= 1'b1;
    lvl_a <= a;
    lvl_b <= b;
    mode <= m;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    check("ready early", ready, 1'b0);
    n = 0;
    while (ready !== 1'b1) begin
      @(posedge clk_i);
      n++;
      if (n > 100) begin
        mismatches++;
        test_done();
      end
    end
    settle();
  endtask

  task automatic wb(input logic we, input logic [7:0] adr,
    input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= {16'h0000, d};
    wb_sel <= 4'h3;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 50) begin
        mismatches++;
        test_done();
      end
    end while (wb_ack !== 1'b1);
    q = wb_dat_r[15:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] adr, input logic [15:0] exp);
    logic [15:0] q;
    wb(1'b0, adr, 16'h0000, q);
    check($sformatf("register %h", adr), q, exp);
  endtask

  task automatic wrreg(input logic [7:0] adr, input logic [15:0] d);
    logic [15:0] q;
    wb(1'b1, adr, d, q);
  endtask

  task automatic link(input logic s, f, r, t);
    @(posedge clk_i);
    speed100 <= s;
    full_dup <= f;
    rx_act <= r;
    tx_act <= t;
    settle();
  endtask

  // Repeater, serial, block code and scrambler bypass strapped high
  task automatic t_repeater();
    boot(psc_pkg::PSC_LVL_0, psc_pkg::PSC_LVL_C, 5'h1b);
    rdchk(8'h5c, 16'h1000);
    rdchk(8'h6c, 16'h0200);
    rdchk(8'h60, 16'h6000);
    rdchk(8'h74, 16'h013c);
    check("advert", an_adv, 4'h3);
    check("monitor", carrier_integrity_monitor, 1'b1);
    link(1'b0, 1'b0, 1'b0, 1'b1);
    check("crs tx only", crs, 1'b0);
    check("serial", serial, 1'b1);
    link(1'b0, 1'b0, 1'b1, 1'b0);
    check("crs rx", crs, 1'b1);
    @(posedge clk_i);
    mii_tx <= '{en: 1'b1, er_d4: 1'b0, data: 4'he};
    rx_data <= 4'h7;
    settle();
    check("tx serial", tx, 6'h20);
    check("rx serial", rxd, 4'h1);
    link(1'b1, 1'b0, 1'b0, 1'b0);
    check("serial at 100", serial, 1'b0);
    check("code bypass", bpc, 1'b1);
    check("scr bypass", bps, 1'b1);
    check("align bypass", bpa, 1'b0);
    @(posedge clk_i);
    mii_tx <= '{en: 1'b0, er_d4: 1'b1, data: 4'h5};
    settle();
    check("tx gated", tx, 6'h05);
  endtask

  // Node mode with alignment bypass only
  task automatic t_node();
    boot(psc_pkg::PSC_LVL_1, psc_pkg::PSC_LVL_1, 5'h04);
    rdchk(8'h5c, 16'h0000);
    rdchk(8'h60, 16'h1000);
    rdchk(8'h6c, 16'h0000);
    check("advert", an_adv, 4'hf);
    check("monitor", carrier_integrity_monitor, 1'b0);
    link(1'b0, 1'b0, 1'b0, 1'b1);
    check("crs tx half", crs, 1'b1);
    check("nibble", serial, 1'b0);
    link(1'b0, 1'b1, 1'b0, 1'b1);
    check("crs tx full", crs, 1'b0);
    link(1'b1, 1'b0, 1'b0, 1'b1);
    check("align bypass", bpa, 1'b1);
    check("crs in align", crs, 1'b0);
    @(posedge clk_i);
    mii_tx <= '{en: 1'b0, er_d4: 1'b1, data: 4'ha};
    rx_data <= 4'h9;
    settle();
    check("tx raw", tx, 6'h1a);
    check("rx data", rxd, 4'h9);
  endtask

  // Live strap changes ignored; software owns the mode bits
  task automatic t_runtime();
    @(posedge clk_i);
    mode <= 5'h1b;
    wrreg(8'h60, 16'h0000);
    wrreg(8'h40, 16'hffff);
    rdchk(8'h40, 16'h0000);
    settle();
    check("align cleared", bpa, 1'b0);
    check("monitor live pin", carrier_integrity_monitor, 1'b0);
    rdchk(8'h5c, 16'h0000);
    wrreg(8'h5c, 16'h1000);
    settle();
    check("monitor by reg", carrier_integrity_monitor, 1'b1);
    // Enable low must hold carrier sense, then release it
    @(posedge clk_i);
    ce <= 1'b0;
    rx_act <= 1'b1;
    settle();
    settle();
    check("crs frozen", crs, 1'b0);
    @(posedge clk_i);
    ce <= 1'b1;
    settle();
    check("crs resumed", crs, 1'b1);
  endtask

  task automatic adv_case(input psc_pkg::psc_level_t a, b,
    input logic [3:0] e);
    boot(a, b, 5'h00);
    check("advert", an_adv, e);
  endtask

  initial begin
    rst_i = 1'b1;
    ce = 1'b1;
    {wb_cyc, wb_stb, wb_we} = 3'h0;
    wb_adr = 8'h00;
    wb_dat_w = 32'h0000_0000;
    wb_sel = 4'h3;
    {speed100, full_dup, rx_act, tx_act} = 4'h0;
    mii_tx = '0;
    rx_data = 4'h0;
    lvl_a = psc_pkg::PSC_LVL_0;
    lvl_b = psc_pkg::PSC_LVL_0;
    mode = 5'h00;
    mismatches = 0;
    samples_checked = 0;
    t_repeater();
    t_node();
    t_runtime();
    adv_case(psc_pkg::PSC_LVL_C, psc_pkg::PSC_LVL_1, 4'ha);
    adv_case(psc_pkg::PSC_LVL_C, psc_pkg::PSC_LVL_0, 4'h5);
    adv_case(psc_pkg::PSC_LVL_1, psc_pkg::PSC_LVL_C, 4'hc);
    adv_case(psc_pkg::PSC_LVL_M, psc_pkg::PSC_LVL_M, 4'hf);
    test_done();
  end
endmodule
